// file: pkg/clock_ctrl_pkg.sv
// constants, register map and rate coding shared by the clocking control block
package clock_ctrl_pkg;

   // clock and detector time base
   localparam int CLK_MHZ       = 200;
   localparam int TICK_NS       = 100;
   localparam int TICK_CYCLES   = (TICK_NS * CLK_MHZ) / 1000;
   localparam int TICKS_PER_SEC = 1000000000 / TICK_NS;
   localparam int TOL_TICKS     = 3;

   // register indices; byte address is four times the index
   localparam logic [13:0] IDX_RATE_ONE    = 14'h0113;
   localparam logic [13:0] IDX_RATE_TWO    = 14'h0114;
   localparam logic [13:0] IDX_STATUS_ONE  = 14'h011B;
   localparam logic [13:0] IDX_STATUS_TWO  = 14'h011C;
   localparam logic [13:0] IDX_SYS_CLKOUT  = 14'h0149;
   localparam logic [13:0] IDX_SEC_CLKOUT  = 14'h014A;
   localparam logic [13:0] IDX_DETECT_CTRL = 14'h0152;
   localparam logic [13:0] IDX_CAND_A      = 14'h0153;
   localparam logic [13:0] IDX_CAND_B      = 14'h0154;
   localparam logic [13:0] IDX_CAND_C      = 14'h0155;
   localparam logic [13:0] IDX_CAND_D      = 14'h0156;
   localparam logic [13:0] IDX_PAD_ONE     = 14'h0C20;
   localparam logic [13:0] IDX_PAD_TWO     = 14'h0C21;

   // field positions
   localparam int ENA_BIT       = 15;
   localparam int DIV_LSB       = 3;
   localparam int SEL_LSB       = 0;
   localparam int FIRST_TRG_BIT = 4;
   localparam int SRC_LSB       = 1;
   localparam int DET_ENA_BIT   = 0;
   localparam int PD_TWO_BIT    = 13;
   localparam int PD_ONE_BIT    = 12;

   // values after reset
   localparam logic [4:0] RATE_SEL_RESET = 5'h11;
   localparam logic [4:0] STATUS_RESET   = 5'h00;
   localparam logic [4:0] CAND_RESET     = 5'h00;

   // detector frame clock source codes
   localparam logic [2:0] SRC_PORT_ONE   = 3'h0;
   localparam logic [2:0] SRC_PORT_TWO   = 3'h2;
   localparam logic [2:0] SRC_PORT_THREE = 3'h4;

   // expected frame period in detector ticks; zero for none or reserved codes
   function automatic logic [11:0] period_ticks(input logic [4:0] code);
      unique case (code)
         5'h01:   return 12'(TICKS_PER_SEC / 12000);
         5'h02:   return 12'(TICKS_PER_SEC / 24000);
         5'h03:   return 12'(TICKS_PER_SEC / 48000);
         5'h04:   return 12'(TICKS_PER_SEC / 96000);
         5'h05:   return 12'(TICKS_PER_SEC / 192000);
         5'h09:   return 12'(TICKS_PER_SEC / 11025);
         5'h0A:   return 12'(TICKS_PER_SEC / 22050);
         5'h0B:   return 12'(TICKS_PER_SEC / 44100);
         5'h0C:   return 12'(TICKS_PER_SEC / 88200);
         5'h0D:   return 12'(TICKS_PER_SEC / 176400);
         5'h11:   return 12'(TICKS_PER_SEC / 8000);
         5'h12:   return 12'(TICKS_PER_SEC / 16000);
         5'h13:   return 12'(TICKS_PER_SEC / 32000);
         default: return 12'h000;
      endcase
   endfunction

   function automatic logic rate_valid(input logic [4:0] code);
      return period_ticks(code) != 12'h000;
   endfunction

   // measured period within tolerance of an expected one
   function automatic logic ticks_near(input logic [11:0] meas, input logic [11:0] expect_t);
      return (expect_t != 12'h000)
          && (({1'b0, meas} + 13'(TOL_TICKS)) >= {1'b0, expect_t})
          && ({1'b0, meas} <= ({1'b0, expect_t} + 13'(TOL_TICKS)));
   endfunction

   // divider codes 0 and 1 both divide by one
   function automatic logic [4:0] divide_ratio(input logic [4:0] code);
      return (code == 5'h00) ? 5'h01 : code;
   endfunction

endpackage

// file: verilog/clock_out_divider.sv
// divided clock output: one high cycle in every ratio cycles while enabled
`timescale 1ns/1ps
module clock_out_divider
   import clock_ctrl_pkg::*;
(
   input  logic       clk,
   input  logic       resetn,
   input  logic       enable,
   input  logic [4:0] divider,
   output logic       clk_out
);

   typedef struct packed {
      logic [4:0] cnt;
      logic       out;
   } state_s;

   state_s s;
   state_s next_s;

   // counter restarts on a short divider so a new code takes hold at once
   always_comb begin
      next_s = s;
      if (!enable) begin
         next_s.cnt = 5'h00;
         next_s.out = 1'b0;
      end else if (s.cnt >= (divide_ratio(divider) - 5'h01)) begin
         next_s.cnt = 5'h00;
         next_s.out = 1'b1;
      end else begin
         next_s.cnt = s.cnt + 5'h01;
         next_s.out = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign clk_out = s.out;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_div_off_low: assert property (!enable |=> !clk_out)
      else $error("divided clock active while disabled");
   // the pulse cycle itself must already see divide by three, since it restarts the count
   a_div_by_three: assert property (
      (clk_out && enable && divider == 5'h03) ##1 (enable && divider == 5'h03) [*2]
      |=> clk_out && !$past(clk_out))
      else $error("divide by three period wrong");

endmodule

// file: verilog/rate_detector.sv
// frame clock period measurement against four candidate rates
`timescale 1ns/1ps
module rate_detector
   import clock_ctrl_pkg::*;
(
   input  logic       clk,
   input  logic       resetn,
   input  logic       enable,
   input  logic       first_trigger,
   input  logic       source_ok,
   input  logic       frame_clock,
   input  logic [4:0] cand_a,
   input  logic [4:0] cand_b,
   input  logic [4:0] cand_c,
   input  logic [4:0] cand_d,
   output logic [4:0] detected_rate,
   output logic       seq_trigger,
   output logic       sample_slip
);

   typedef struct packed {
      logic        frame_prev;
      logic [4:0]  tick_cnt;
      logic [11:0] period;
      logic        started;
      logic        locked;
      logic        first_seen;
      logic [4:0]  rate;
      logic        trig;
      logic        slip;
   } state_s;

   localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);

   state_s s;
   state_s next_s;
   logic [3:0][4:0] cands;
   logic            hit;
   logic [4:0]      hit_code;

   assign cands = {cand_d, cand_c, cand_b, cand_a};

   // candidate A has the highest priority, so scan from D downward
   always_comb begin
      hit      = 1'b0;
      hit_code = 5'h00;
      for (int i = 3; i >= 0; i--) begin
         if (ticks_near(s.period, period_ticks(cands[i]))) begin
            hit      = 1'b1;
            hit_code = cands[i];
         end
      end
   end

   // period counted in ticks keeps the counter small at the cost of resolution
   always_comb begin
      next_s            = s;
      next_s.trig       = 1'b0;
      next_s.slip       = 1'b0;
      next_s.frame_prev = frame_clock;
      if (!enable || !source_ok) begin
         next_s.tick_cnt   = 5'h00;
         next_s.period     = 12'h000;
         next_s.started    = 1'b0;
         next_s.locked     = 1'b0;
         next_s.first_seen = 1'b0;
         next_s.rate       = 5'h00;
      end else if (frame_clock && !s.frame_prev) begin
         next_s.started  = 1'b1;
         next_s.period   = 12'h000;
         next_s.tick_cnt = 5'h00;
         if (s.started && hit && (!s.locked || hit_code != s.rate)) begin
            next_s.rate       = hit_code;
            next_s.locked     = 1'b1;
            next_s.first_seen = 1'b1;
            next_s.trig       = s.first_seen || first_trigger;
         end else if (s.started && s.locked
                      && !ticks_near(s.period, period_ticks(s.rate))) begin
            next_s.slip = 1'b1;
         end
      end else if (s.tick_cnt == TICK_LAST) begin
         next_s.tick_cnt = 5'h00;
         if (s.period != 12'hFFF) begin
            next_s.period = s.period + 12'h001;
         end
      end else begin
         next_s.tick_cnt = s.tick_cnt + 5'h01;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign detected_rate = s.rate;
   assign seq_trigger   = s.trig;
   assign sample_slip   = s.slip;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_first_no_trig: assert property (
      seq_trigger && !$past(first_trigger) |-> $past(s.first_seen))
      else $error("sequencer triggered on initial detection");
   a_off_clears: assert property (!enable |=> !s.locked && !seq_trigger)
      else $error("detector active while disabled");
   a_slip_locked: assert property (sample_slip |-> s.locked && $past(s.locked))
      else $error("sample slip without a locked rate");

endmodule

// file: verilog/async_rate_divided_system_clock_out_rate_detect.sv
// clocking control: second-domain rates, divided clock outputs, rate detector, pads
`timescale 1ns/1ps
module async_rate_divided_system_clock_out_rate_detect
   import clock_ctrl_pkg::*;
(
   input  logic        CLK,
   input  logic        RESETN,
   input  logic        PSEL,
   input  logic        PENABLE,
   input  logic        PWRITE,
   input  logic [15:0] PADDR,
   input  logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic        PREADY,
   output logic        PSLVERR,
   input  logic        PORT_ONE_FRAME_CLOCK,
   input  logic        PORT_TWO_FRAME_CLOCK,
   input  logic        PORT_THREE_FRAME_CLOCK,
   output logic        DIVIDED_SYSTEM_CLOCK_OUT,
   output logic        DIVIDED_SECOND_CLOCK_OUT,
   output logic [2:0]  SYS_CLKOUT_SOURCE_FREQ,
   output logic [2:0]  SECOND_CLKOUT_SOURCE_FREQ,
   output logic        MASTER_CLOCK_ONE_PULLDOWN,
   output logic        MASTER_CLOCK_TWO_PULLDOWN,
   output logic        SEQUENCER_TRIGGER,
   output logic        SAMPLE_SLIP,
   output logic [4:0]  DETECTED_RATE
);

   typedef struct packed {
      logic [4:0]      rate_one;
      logic [4:0]      rate_two;
      logic [4:0]      status_one;
      logic [4:0]      status_two;
      logic            sys_ena;
      logic [4:0]      sys_div;
      logic [2:0]      sys_sel;
      logic            sec_ena;
      logic [4:0]      sec_div;
      logic [2:0]      sec_sel;
      logic            first_trg;
      logic [2:0]      det_src;
      logic            det_ena;
      logic [3:0][4:0] cand;
      logic            pd_two;
      logic            pd_one;
      logic [2:0]      sync_a;
      logic [2:0]      sync_b;
      logic [31:0]     rdata;
      logic            err;
   } state_s;

   localparam state_s STATE_RESET = '{
      rate_one:   RATE_SEL_RESET,
      rate_two:   RATE_SEL_RESET,
      status_one: STATUS_RESET,
      status_two: STATUS_RESET,
      cand:       {4{CAND_RESET}},
      default:    '0
   };

   state_s      s;
   state_s      next_s;
   logic        setup;
   logic        access;
   logic [13:0] idx;
   logic        aligned;
   logic        src_ok;
   logic        frame_sel;
   logic [31:0] rd;
   logic        rd_hit;

   assign setup   = PSEL && !PENABLE;
   assign access  = PSEL && PENABLE;
   assign idx     = PADDR[15:2];
   assign aligned = (PADDR[1:0] == 2'b00);

   // detector source decode; reserved codes leave the detector blind
   always_comb begin
      src_ok    = 1'b1;
      frame_sel = 1'b0;
      unique case (s.det_src)
         SRC_PORT_ONE:   frame_sel = s.sync_b[0];
         SRC_PORT_TWO:   frame_sel = s.sync_b[1];
         SRC_PORT_THREE: frame_sel = s.sync_b[2];
         default:        src_ok    = 1'b0;
      endcase
   end

   // read image of the addressed register; bits above each field read zero
   always_comb begin
      rd     = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (idx)
         IDX_RATE_ONE:   rd[4:0] = s.rate_one;
         IDX_RATE_TWO:   rd[4:0] = s.rate_two;
         IDX_STATUS_ONE: rd[4:0] = s.status_one;
         IDX_STATUS_TWO: rd[4:0] = s.status_two;
         IDX_SYS_CLKOUT: begin
            rd[ENA_BIT]         = s.sys_ena;
            rd[DIV_LSB +: 5]    = s.sys_div;
            rd[SEL_LSB +: 3]    = s.sys_sel;
         end
         IDX_SEC_CLKOUT: begin
            rd[ENA_BIT]         = s.sec_ena;
            rd[DIV_LSB +: 5]    = s.sec_div;
            rd[SEL_LSB +: 3]    = s.sec_sel;
         end
         IDX_DETECT_CTRL: begin
            rd[FIRST_TRG_BIT]   = s.first_trg;
            rd[SRC_LSB +: 3]    = s.det_src;
            rd[DET_ENA_BIT]     = s.det_ena;
         end
         IDX_CAND_A:     rd[4:0] = s.cand[0];
         IDX_CAND_B:     rd[4:0] = s.cand[1];
         IDX_CAND_C:     rd[4:0] = s.cand[2];
         IDX_CAND_D:     rd[4:0] = s.cand[3];
         IDX_PAD_ONE:    rd[PD_TWO_BIT] = s.pd_two;
         IDX_PAD_TWO:    rd[PD_ONE_BIT] = s.pd_one;
         default:        rd_hit = 1'b0;
      endcase
   end

   // next state: synchronisers, status copies and the APB register file
   always_comb begin
      next_s = s;

      // frame clocks are pins, so two flops before anything looks at them
      next_s.sync_a = {PORT_THREE_FRAME_CLOCK, PORT_TWO_FRAME_CLOCK, PORT_ONE_FRAME_CLOCK};
      next_s.sync_b = s.sync_a;

      // status shows the rate in force; a reserved select shows none
      next_s.status_one = rate_valid(s.rate_one) ? s.rate_one : STATUS_RESET;
      next_s.status_two = rate_valid(s.rate_two) ? s.rate_two : STATUS_RESET;

      // read data and error are captured in the setup cycle
      if (setup) begin
         next_s.err   = !(aligned && rd_hit);
         next_s.rdata = (aligned && rd_hit) ? rd : 32'h0000_0000;
      end

      // writes land at the access edge; status indices have no write path
      if (access && PWRITE && !s.err) begin
         unique case (idx)
            IDX_RATE_ONE: begin
               next_s.rate_one = PWDATA[4:0];
            end
            IDX_RATE_TWO: begin
               next_s.rate_two = PWDATA[4:0];
            end
            IDX_SYS_CLKOUT: begin
               next_s.sys_ena = PWDATA[ENA_BIT];
               next_s.sys_div = PWDATA[DIV_LSB +: 5];
               next_s.sys_sel = PWDATA[SEL_LSB +: 3];
            end
            IDX_SEC_CLKOUT: begin
               next_s.sec_ena = PWDATA[ENA_BIT];
               next_s.sec_div = PWDATA[DIV_LSB +: 5];
               next_s.sec_sel = PWDATA[SEL_LSB +: 3];
            end
            IDX_DETECT_CTRL: begin
               next_s.first_trg = PWDATA[FIRST_TRG_BIT];
               next_s.det_src   = PWDATA[SRC_LSB +: 3];
               next_s.det_ena   = PWDATA[DET_ENA_BIT];
            end
            IDX_CAND_A: begin
               next_s.cand[0] = PWDATA[4:0];
            end
            IDX_CAND_B: begin
               next_s.cand[1] = PWDATA[4:0];
            end
            IDX_CAND_C: begin
               next_s.cand[2] = PWDATA[4:0];
            end
            IDX_CAND_D: begin
               next_s.cand[3] = PWDATA[4:0];
            end
            IDX_PAD_ONE: begin
               next_s.pd_two = PWDATA[PD_TWO_BIT];
            end
            IDX_PAD_TWO: begin
               next_s.pd_one = PWDATA[PD_ONE_BIT];
            end
            default: begin
               next_s.err = s.err;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         s <= STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // both outputs count on CLK; the source frequency fields go out as ports
   clock_out_divider u_sys_div (
      .clk     (CLK),
      .resetn  (RESETN),
      .enable  (s.sys_ena),
      .divider (s.sys_div),
      .clk_out (DIVIDED_SYSTEM_CLOCK_OUT)
   );

   clock_out_divider u_sec_div (
      .clk     (CLK),
      .resetn  (RESETN),
      .enable  (s.sec_ena),
      .divider (s.sec_div),
      .clk_out (DIVIDED_SECOND_CLOCK_OUT)
   );

   rate_detector u_detect (
      .clk           (CLK),
      .resetn        (RESETN),
      .enable        (s.det_ena),
      .first_trigger (s.first_trg),
      .source_ok     (src_ok),
      .frame_clock   (frame_sel),
      .cand_a        (s.cand[0]),
      .cand_b        (s.cand[1]),
      .cand_c        (s.cand[2]),
      .cand_d        (s.cand[3]),
      .detected_rate (DETECTED_RATE),
      .seq_trigger   (SEQUENCER_TRIGGER),
      .sample_slip   (SAMPLE_SLIP)
   );

   // bus answer: no wait states, data and error held from the setup cycle
   assign PREADY  = access;
   assign PRDATA  = s.rdata;
   assign PSLVERR = access && s.err;

   // pad and source frequency outputs come straight from register bits
   assign SYS_CLKOUT_SOURCE_FREQ    = s.sys_sel;
   assign SECOND_CLKOUT_SOURCE_FREQ = s.sec_sel;
   assign MASTER_CLOCK_TWO_PULLDOWN = s.pd_two;
   assign MASTER_CLOCK_ONE_PULLDOWN = s.pd_one;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   sequence apb_setup;
      PSEL && !PENABLE;
   endsequence

   sequence apb_write(logic [13:0] at);
      PSEL && PENABLE && PWRITE && !s.err && idx == at;
   endsequence

   a_apb_answer: assert property (
      apb_setup ##1 (PSEL && PENABLE) |-> PREADY && PRDATA[31:16] == 16'h0000)
      else $error("access phase without a clean answer");
   a_rate_one_wr: assert property (
      apb_write(IDX_RATE_ONE) |=> s.rate_one == $past(PWDATA[4:0]))
      else $error("rate select one not written");
   a_status_copy: assert property (
      rate_valid(s.rate_two) |=> s.status_two == $past(s.rate_two))
      else $error("status two does not follow its select");
   a_status_none: assert property (
      !rate_valid(s.rate_one) |=> s.status_one == STATUS_RESET)
      else $error("status one shows a reserved rate");
   a_sys_out_off: assert property (
      !s.sys_ena ##1 !s.sys_ena |-> !DIVIDED_SYSTEM_CLOCK_OUT)
      else $error("system clock output runs while disabled");
   a_sys_sel_pin: assert property (
      apb_write(IDX_SYS_CLKOUT) |=> SYS_CLKOUT_SOURCE_FREQ == $past(PWDATA[2:0]))
      else $error("system output source frequency not applied");
   a_pad_one_pin: assert property (
      apb_write(IDX_PAD_ONE) |=> MASTER_CLOCK_TWO_PULLDOWN == $past(PWDATA[PD_TWO_BIT]))
      else $error("pull-down of master clock two not applied");
   a_pad_two_pin: assert property (
      apb_write(IDX_PAD_TWO) |=> MASTER_CLOCK_ONE_PULLDOWN == $past(PWDATA[PD_ONE_BIT]))
      else $error("pull-down of master clock one not applied");
   a_reserved_src: assert property (!src_ok |=> !SEQUENCER_TRIGGER && !SAMPLE_SLIP)
      else $error("detector reports with a reserved source");

endmodule

// file: verification/async_rate_divided_system_clock_out_rate_detect_tb.sv
// self-checking testbench for the clocking control block
`timescale 1ns/1ps
module async_rate_divided_system_clock_out_rate_detect_tb
   import clock_ctrl_pkg::*;
;
   logic        clk, resetn, psel, penable, pwrite, f1, f2, f3, err;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, osys, osec, pd1, pd2, trig, slip;
   logic [2:0]  fsys, fsec;
   logic [4:0]  rate;
   int          n_errors, compares, trig_count, slip_count;

   async_rate_divided_system_clock_out_rate_detect uut (.CLK(clk), .RESETN(resetn), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PORT_ONE_FRAME_CLOCK(f1),
      .PORT_TWO_FRAME_CLOCK(f2), .PORT_THREE_FRAME_CLOCK(f3),
      .DIVIDED_SYSTEM_CLOCK_OUT(osys), .DIVIDED_SECOND_CLOCK_OUT(osec),
      .SYS_CLKOUT_SOURCE_FREQ(fsys), .SECOND_CLKOUT_SOURCE_FREQ(fsec),
      .MASTER_CLOCK_ONE_PULLDOWN(pd1), .MASTER_CLOCK_TWO_PULLDOWN(pd2),
      .SEQUENCER_TRIGGER(trig), .SAMPLE_SLIP(slip), .DETECTED_RATE(rate));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // count trigger and slip pulses; each one stands for a single cycle
   always @(posedge clk) begin
      if (trig === 1'b1) trig_count <= trig_count + 1;
      if (slip === 1'b1) slip_count <= slip_count + 1;
   end

   task automatic close_out;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n >= 50) chk("pready wait", 32'h1, 32'h0);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic wr(input logic [13:0] i, input logic [31:0] d);
      apb(1'b1, {i, 2'b00}, d);
      chk("write error", 32'h0, {31'h0, err});
      repeat (3) @(posedge clk);
   endtask

   task automatic rdc(input string what, input logic [13:0] i, input logic [31:0] exp);
      apb(1'b0, {i, 2'b00}, 32'h0);
      chk(what, exp, rd);
   endtask

   task automatic t_regs;
      rdc("rate one", IDX_RATE_ONE, 32'h11);
      rdc("rate two", IDX_RATE_TWO, 32'h11);
      rdc("status one", IDX_STATUS_ONE, 32'h11);
      wr(IDX_STATUS_ONE, 32'h3);
      rdc("status one", IDX_STATUS_ONE, 32'h11);
      wr(IDX_RATE_TWO, 32'h0B);
      rdc("status two", IDX_STATUS_TWO, 32'h0B);
      // reserved codes are kept as written but mirror as none
      wr(IDX_RATE_ONE, 32'h07);
      rdc("rate one", IDX_RATE_ONE, 32'h07);
      rdc("status one", IDX_STATUS_ONE, 32'h00);
      rdc("detector ctrl", IDX_DETECT_CTRL, 32'h0);
      rdc("candidate d", IDX_CAND_D, 32'h0);
      apb(1'b0, 16'h0400, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
   endtask

   // program one clock output, then count its high cycles over 60 cycles
   task automatic clk_run(input logic sec, input logic [15:0] v, input int hi, input logic [2:0] s);
      int cnt;
      cnt = 0;
      wr(sec ? IDX_SEC_CLKOUT : IDX_SYS_CLKOUT, {16'h0, v});
      repeat (40) @(posedge clk);
      repeat (60) begin
         @(posedge clk);
         cnt += ((sec ? osec : osys) === 1'b1);
      end
      chk("clock out highs", hi, cnt);
      chk("source freq", {29'h0, s}, {29'h0, sec ? fsec : fsys});
   endtask

   task automatic t_clkout;
      clk_run(1'b0, 16'h802B, 12, 3'h3);
      clk_run(1'b0, 16'h801B, 20, 3'h3);
      clk_run(1'b0, 16'h8002, 60, 3'h2);
      clk_run(1'b0, 16'h0029, 0, 3'h1);
      clk_run(1'b1, 16'h8053, 6, 3'h3);
      clk_run(1'b1, 16'h800A, 60, 3'h2);
      clk_run(1'b1, 16'h0000, 0, 3'h0);
   endtask

   task automatic t_pads;
      wr(IDX_PAD_ONE, 32'h2000);
      chk("pulldown two", 32'h1, {31'h0, pd2});
      chk("pulldown one", 32'h0, {31'h0, pd1});
      wr(IDX_PAD_TWO, 32'h1000);
      chk("pulldown one", 32'h1, {31'h0, pd1});
      rdc("pad one", IDX_PAD_ONE, 32'h2000);
   endtask

   task automatic fset(input int p, input logic v);
      case (p)
         1: f1 <= v;
         2: f2 <= v;
         default: f3 <= v;
      endcase
   endtask

   // n frame periods of 2*half cycles on port p, then settle
   task automatic frames(input int p, input int half, input int n);
      repeat (n) begin
         @(posedge clk) fset(p, 1'b1);
         repeat (half - 1) @(posedge clk);
         @(posedge clk) fset(p, 1'b0);
         repeat (half - 1) @(posedge clk);
      end
      repeat (10) @(posedge clk);
   endtask

   task automatic t_detect;
      wr(IDX_CAND_A, 32'h04);
      wr(IDX_CAND_B, 32'h05);
      wr(IDX_DETECT_CTRL, 32'h01);
      // frames are built from clk, so the port domains stay locked to them
      // 96 kHz is 104 ticks of 20 cycles
      frames(1, 1040, 3);
      chk("detected rate", 32'h04, {27'h0, rate});
      chk("triggers", 32'h0, trig_count);
      // a 70 tick period matches no candidate, so the locked rate slips
      frames(1, 700, 2);
      chk("detected rate", 32'h04, {27'h0, rate});
      chk("slips", 32'h1, slip_count);
      frames(1, 520, 3);
      chk("detected rate", 32'h05, {27'h0, rate});
      chk("triggers", 32'h1, trig_count);
      chk("slips", 32'h2, slip_count);
      // moving to port two keeps the lock; the change to A triggers
      wr(IDX_DETECT_CTRL, 32'h05);
      frames(2, 1040, 3);
      chk("detected rate", 32'h04, {27'h0, rate});
      chk("triggers", 32'h2, trig_count);
      wr(IDX_DETECT_CTRL, 32'h13);
      frames(1, 1040, 3);
      chk("detected rate", 32'h0, {27'h0, rate});
      chk("triggers", 32'h2, trig_count);
      wr(IDX_DETECT_CTRL, 32'h19);
      frames(3, 1040, 3);
      chk("detected rate", 32'h04, {27'h0, rate});
      chk("triggers", 32'h3, trig_count);
      chk("slips", 32'h2, slip_count);
   endtask

   initial begin
      {resetn, psel, penable, pwrite, f1, f2, f3} = 7'h0;
      paddr = 16'h0; pwdata = 32'h0; n_errors = 0; compares = 0; trig_count = 0;
      slip_count = 0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      t_regs;
      t_clkout;
      t_pads;
      t_detect;
      close_out;
   end

   // watchdog well beyond the expected run of about 32k cycles
   initial begin
      repeat (80000) @(posedge clk);
      n_errors++;
      $display("watchdog expired");
      close_out;
   end
endmodule
